/* File: rtl/cesc_bank.v */
// Serially programmed clock enable and spread control register bank
`include "cesc_regs.vh"

module cesc_bank (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Serial pins, open drain data
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n,
	// Power down pin, low means powered down
	input wire pd_n,
	// Control bytes
	output wire [7:0] host_clock_enable_byte,
	output wire [7:0] memory_clock_enable_byte,
	output wire [7:0] mid_clock_enable_byte,
	output wire [7:0] pci_clock_enable_byte,
	output wire [7:0] video_clock_select_byte,
	output wire [7:0] spread_control_byte,
	// Derived spread controls
	output wire spread_modulation_on,
	output wire video_spread_active,
	output wire spread_mean_lowered,
	output wire [1:0] spread_width_active
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_ACK = 3'h2;
	localparam [2:0] ST_WRITE = 3'h3;
	localparam [2:0] ST_READ = 3'h4;
	localparam [2:0] ST_RACK = 3'h5;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg scl_m_r, scl_s_r, scl_d_r;
	reg sda_m_r, sda_s_r, sda_d_r;
	reg pd_m_r, pd_s_r;

	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
			pd_m_r <= 1'b1;
			pd_s_r <= 1'b1;
		end
		else
		begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
			pd_m_r <= pd_n;
			pd_s_r <= pd_m_r;
		end
	end

	wire scl_rise = scl_s_r & ~scl_d_r;
	wire scl_fall = ~scl_s_r & scl_d_r;
	wire bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// ----------------------------------------
	// Transfer engine
	// ----------------------------------------
	reg [2:0] state_r, rd_idx_r, wr_sel_r;
	reg [3:0] bit_cnt_r, wr_idx_r;
	reg [7:0] shift_r, tx_r, wr_data_r;
	reg read_mode_r, host_nak_r, sda_oe_n_r, sda_out_r, wr_en_r;

	reg [7:0] host_r, memory_r, mid_r, pci_r, video_r, spread_r;
	reg [7:0] rd_byte;

	// Read mux for the byte about to be returned
	always @*
	begin
		case (rd_idx_r)
			`CESC_HOST_BYTE: rd_byte = host_r;
			`CESC_MEMORY_BYTE: rd_byte = memory_r;
			`CESC_MID_BYTE: rd_byte = mid_r;
			`CESC_PCI_BYTE: rd_byte = pci_r;
			`CESC_VIDEO_BYTE: rd_byte = video_r;
			default: rd_byte = spread_r;
		endcase
	end

	wire [2:0] rd_idx_next = (rd_idx_r == `CESC_LAST_BYTE_IDX) ? `CESC_HOST_BYTE : rd_idx_r + 3'h1;
	wire [3:0] wr_data_idx = wr_idx_r - `CESC_PREAMBLE_BYTES;

	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			wr_idx_r <= 4'h0;
			rd_idx_r <= 3'h0;
			read_mode_r <= 1'b0;
			host_nak_r <= 1'b0;
			sda_oe_n_r <= 1'b1;
			sda_out_r <= 1'b0;
			wr_en_r <= 1'b0;
			wr_sel_r <= 3'h0;
			wr_data_r <= 8'h00;
		end
		else
		begin
			wr_en_r <= 1'b0;
			sda_out_r <= 1'b0;
			// Pins are tri-stated in power down; the bank itself is kept
			if (!pd_s_r)
			begin
				state_r <= ST_IDLE;
				sda_oe_n_r <= 1'b1;
			end
			else if (bus_start)
			begin
				state_r <= ST_ADDR;
				bit_cnt_r <= 4'h0;
				wr_idx_r <= 4'h0;
				rd_idx_r <= `CESC_HOST_BYTE;
				sda_oe_n_r <= 1'b1;
			end
			else if (bus_stop)
			begin
				// A short transfer leaves unsent bytes alone
				state_r <= ST_IDLE;
				sda_oe_n_r <= 1'b1;
			end
			else
			begin
				case (state_r)
					ST_IDLE:
					begin
						sda_oe_n_r <= 1'b1;
					end
					ST_ADDR, ST_WRITE:
					begin
						if (scl_rise && bit_cnt_r != `CESC_BITS_PER_BYTE)
						begin
							shift_r <= {shift_r[6:0], sda_s_r};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
						else if (scl_fall && bit_cnt_r == `CESC_BITS_PER_BYTE)
						begin
							bit_cnt_r <= 4'h0;
							if (state_r == ST_ADDR)
							begin
								if (shift_r == `CESC_ADDR_WRITE)
								begin
									read_mode_r <= 1'b0;
									sda_oe_n_r <= 1'b0;
									state_r <= ST_ACK;
								end
								else if (shift_r == `CESC_ADDR_READ)
								begin
									read_mode_r <= 1'b1;
									sda_oe_n_r <= 1'b0;
									state_r <= ST_ACK;
								end
								else
								begin
									state_r <= ST_IDLE;
								end
							end
							else if (wr_idx_r <= `CESC_LAST_WRITE_IDX)
							begin
								// Command and count are acked but never decoded
								sda_oe_n_r <= 1'b0;
								state_r <= ST_ACK;
								wr_idx_r <= wr_idx_r + 4'h1;
								if (wr_idx_r >= `CESC_PREAMBLE_BYTES)
								begin
									wr_en_r <= 1'b1;
									wr_sel_r <= wr_data_idx[2:0];
									wr_data_r <= shift_r;
								end
							end
							else
							begin
								// Beyond the last byte the host sees no ack
								state_r <= ST_IDLE;
							end
						end
					end
					ST_ACK:
					begin
						if (scl_fall)
						begin
							bit_cnt_r <= 4'h0;
							if (read_mode_r)
							begin
								tx_r <= rd_byte;
								sda_oe_n_r <= rd_byte[7];
								rd_idx_r <= rd_idx_next;
								state_r <= ST_READ;
							end
							else
							begin
								sda_oe_n_r <= 1'b1;
								state_r <= ST_WRITE;
							end
						end
					end
					ST_READ:
					begin
						if (scl_fall)
						begin
							if (bit_cnt_r == `CESC_LAST_READ_BIT)
							begin
								sda_oe_n_r <= 1'b1;
								state_r <= ST_RACK;
							end
							else
							begin
								tx_r <= {tx_r[6:0], 1'b0};
								sda_oe_n_r <= tx_r[6];
								bit_cnt_r <= bit_cnt_r + 4'h1;
							end
						end
					end
					ST_RACK:
					begin
						if (scl_rise)
						begin
							host_nak_r <= sda_s_r;
						end
						else if (scl_fall)
						begin
							bit_cnt_r <= 4'h0;
							if (host_nak_r)
							begin
								state_r <= ST_IDLE;
							end
							else
							begin
								// Bytes come back in order, wrapping after the last
								tx_r <= rd_byte;
								sda_oe_n_r <= rd_byte[7];
								rd_idx_r <= rd_idx_next;
								state_r <= ST_READ;
							end
						end
					end
					default:
					begin
						state_r <= ST_IDLE;
						sda_oe_n_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Control bytes
	// ----------------------------------------
	// Reserved bits are forced to zero so they read back as zero
	// even if the host ignores them
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			host_r <= `CESC_HOST_RESET;
			memory_r <= `CESC_MEMORY_RESET;
			mid_r <= `CESC_MID_RESET;
			pci_r <= `CESC_PCI_RESET;
			video_r <= `CESC_VIDEO_RESET;
			spread_r <= `CESC_SPREAD_RESET;
		end
		else if (wr_en_r)
		begin
			// Only the addressed byte changes; power down does not touch them
			case (wr_sel_r)
				`CESC_HOST_BYTE: host_r <= wr_data_r & `CESC_HOST_MASK;
				`CESC_MEMORY_BYTE: memory_r <= wr_data_r & `CESC_MEMORY_MASK;
				`CESC_MID_BYTE: mid_r <= wr_data_r & `CESC_MID_MASK;
				`CESC_PCI_BYTE: pci_r <= wr_data_r & `CESC_PCI_MASK;
				`CESC_VIDEO_BYTE: video_r <= wr_data_r & `CESC_VIDEO_MASK;
				`CESC_SPREAD_BYTE: spread_r <= wr_data_r & `CESC_SPREAD_MASK;
				default: spread_r <= spread_r;
			endcase
		end
	end

	// ----------------------------------------
	// Derived spread controls
	// ----------------------------------------
	// Registered one cycle behind the bytes so every output is a flop
	reg spread_on_r, video_spread_r, mean_low_r;
	reg [1:0] width_r;

	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			spread_on_r <= 1'b0;
			video_spread_r <= 1'b0;
			mean_low_r <= 1'b0;
			width_r <= 2'h0;
		end
		else
		begin
			spread_on_r <= host_r[`CESC_SPREAD_EN_BIT];
			video_spread_r <= video_r[`CESC_VIDEO_SRC_BIT] & host_r[`CESC_SPREAD_EN_BIT];
			// Down mode shifts the mean by half the width; center keeps it
			mean_low_r <= host_r[`CESC_SPREAD_EN_BIT] & ~spread_r[`CESC_SPREAD_MODE_BIT];
			// Width code read with the mode bit as down or center table
			width_r <= host_r[`CESC_SPREAD_EN_BIT] ? spread_r[`CESC_WIDTH_HI:`CESC_WIDTH_LO] : 2'h0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sda_out = sda_out_r;
	assign sda_oe_n = sda_oe_n_r;
	assign host_clock_enable_byte = host_r;
	assign memory_clock_enable_byte = memory_r;
	assign mid_clock_enable_byte = mid_r;
	assign pci_clock_enable_byte = pci_r;
	assign video_clock_select_byte = video_r;
	assign spread_control_byte = spread_r;
	assign spread_modulation_on = spread_on_r;
	assign video_spread_active = video_spread_r;
	assign spread_mean_lowered = mean_low_r;
	assign spread_width_active = width_r;

endmodule // cesc_bank

/* File: rtl/cesc_regs.vh */
// Constants for the clock enable and spread control bank
`ifndef CESC_REGS_VH
`define CESC_REGS_VH

// ----------------------------------------
// Serial addresses
// ----------------------------------------
`define CESC_ADDR_WRITE 8'hD2
`define CESC_ADDR_READ 8'hD3

// ----------------------------------------
// Transfer layout
// ----------------------------------------
`define CESC_PREAMBLE_BYTES 4'h2
`define CESC_LAST_WRITE_IDX 4'h7
`define CESC_LAST_BYTE_IDX 3'h5
`define CESC_BITS_PER_BYTE 4'h8
`define CESC_LAST_READ_BIT 4'h7

// ----------------------------------------
// Byte indexes
// ----------------------------------------
`define CESC_HOST_BYTE 3'h0
`define CESC_MEMORY_BYTE 3'h1
`define CESC_MID_BYTE 3'h2
`define CESC_PCI_BYTE 3'h3
`define CESC_VIDEO_BYTE 3'h4
`define CESC_SPREAD_BYTE 3'h5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CESC_HOST_RESET 8'hF6
`define CESC_MEMORY_RESET 8'h3F
`define CESC_MID_RESET 8'hE0
`define CESC_PCI_RESET 8'h7E
`define CESC_VIDEO_RESET 8'h00
`define CESC_SPREAD_RESET 8'h00

// ----------------------------------------
// Writable bit masks, reserved bits cleared
// ----------------------------------------
`define CESC_HOST_MASK 8'hFE
`define CESC_MEMORY_MASK 8'h3F
`define CESC_MID_MASK 8'hE0
`define CESC_PCI_MASK 8'h7F
`define CESC_VIDEO_MASK 8'h80
`define CESC_SPREAD_MASK 8'hE3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CESC_SPREAD_EN_BIT 3
`define CESC_MEM133_BIT 0
`define CESC_VIDEO_SRC_BIT 7
`define CESC_SPREAD_MODE_BIT 7
`define CESC_WIDTH_HI 6
`define CESC_WIDTH_LO 5
`define CESC_ESEL_HI 1
`define CESC_ESEL_LO 0

`endif

/* File: bench/cesc_bank_properties.sv */
// Concurrent checks on the ports of the control register bank
`include "cesc_regs.vh"
module cesc_bank_properties (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Serial and power down pins
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire pd_n,
	// Control bytes
	input wire [7:0] host_clock_enable_byte,
	input wire [7:0] memory_clock_enable_byte,
	input wire [7:0] mid_clock_enable_byte,
	input wire [7:0] pci_clock_enable_byte,
	input wire [7:0] video_clock_select_byte,
	input wire [7:0] spread_control_byte,
	// Derived spread controls
	input wire spread_modulation_on,
	input wire video_spread_active,
	input wire spread_mean_lowered,
	input wire [1:0] spread_width_active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire [7:0] h = host_clock_enable_byte;
	wire [7:0] s = spread_control_byte;
	wire [47:0] all_b = {s, video_clock_select_byte, pci_clock_enable_byte,
		mid_clock_enable_byte, memory_clock_enable_byte, h};
	wire [47:0] msk = {`CESC_SPREAD_MASK, `CESC_VIDEO_MASK, `CESC_PCI_MASK,
		`CESC_MID_MASK, `CESC_MEMORY_MASK, `CESC_HOST_MASK};
	// Synchroniser delay means the pin must be low a while before it counts
	sequence pd_held;
		!pd_n [*6];
	endsequence
	a_mod_on: assert property (h[3] |=> spread_modulation_on) else $error("modulation off");
	a_mod_off: assert property (!h[3] |=> !spread_modulation_on) else $error("modulation on");
	a_video_gate: assert property (video_spread_active == $past(video_clock_select_byte[7] & h[3]))
		else $error("video spread ungated");
	a_mean_low: assert property (spread_mean_lowered == $past(h[3] & ~s[7])) else $error("mean flag");
	a_width_gate: assert property (spread_width_active == ($past(h[3]) ? $past(s[6:5]) : 2'h0))
		else $error("width gating");
	a_rsvd_zero: assert property ((all_b & ~msk) == 48'h0) else $error("reserved bit set");
	a_pd_keep: assert property (pd_held |=> $stable(all_b)) else $error("bytes moved in power down");
	a_pd_quiet: assert property (pd_held |-> sda_oe_n) else $error("data driven in power down");
	a_change_acked: assert property ($changed(all_b) |-> !sda_oe_n) else $error("byte changed unacked");
	a_open_drain: assert property (!sda_oe_n |-> !sda_out) else $error("data driven high");
endmodule // cesc_bank_properties

/* File: bench/cesc_smbus_host.sv */
// Serial bus host model: drives clock and data, reads the resolved wire
module cesc_smbus_host (
	// Clock
	input wire mclk,
	// Serial lines
	output logic scl,
	output logic sda_h,
	input wire sda
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// Data moves only while the clock is low
	task bit_x(input logic b, output logic r);
		sda_h = b;
		repeat (6) @(negedge mclk);
		scl = 1'b1;
		repeat (3) @(negedge mclk);
		r = sda;
		repeat (3) @(negedge mclk);
		scl = 1'b0;
	endtask
	task start;
		sda_h = 1'b1;
		repeat (3) @(negedge mclk);
		scl = 1'b1;
		repeat (6) @(negedge mclk);
		sda_h = 1'b0;
		repeat (6) @(negedge mclk);
		scl = 1'b0;
	endtask
	task stop;
		sda_h = 1'b0;
		repeat (3) @(negedge mclk);
		scl = 1'b1;
		repeat (6) @(negedge mclk);
		sda_h = 1'b1;
		repeat (6) @(negedge mclk);
	endtask
	// Sends d MSB first, then gives last on the ninth clock
	task xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(last, r);
		ack = !r;
	endtask
endmodule // cesc_smbus_host

/* File: bench/tb.sv */
// Testbench for the control register bank
`include "cesc_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst, pd_n, a;
	wire scl, sda_h, sda_out, sda_oe_n, smo, vsa, sml;
	wire [1:0] swa;
	wire [7:0] b0, b1, b2, b3, b4, b5;
	// Pull-up: any party pulling low wins
	wire sda = sda_h & (sda_oe_n | sda_out);
	wire [47:0] all_b = {b5, b4, b3, b2, b1, b0};
	localparam logic [47:0] MSK = {`CESC_SPREAD_MASK, `CESC_VIDEO_MASK, `CESC_PCI_MASK,
		`CESC_MID_MASK, `CESC_MEMORY_MASK, `CESC_HOST_MASK};
	localparam logic [47:0] RSTV = {`CESC_SPREAD_RESET, `CESC_VIDEO_RESET, `CESC_PCI_RESET,
		`CESC_MID_RESET, `CESC_MEMORY_RESET, `CESC_HOST_RESET};
	int err_total, checks_done;
	logic [7:0] v [7];
	logic [7:0] q;
	logic [47:0] e;
	cesc_bank cesc_bank_i (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .pd_n(pd_n), .host_clock_enable_byte(b0), .memory_clock_enable_byte(b1),
		.mid_clock_enable_byte(b2), .pci_clock_enable_byte(b3), .video_clock_select_byte(b4),
		.spread_control_byte(b5), .spread_modulation_on(smo), .video_spread_active(vsa),
		.spread_mean_lowered(sml), .spread_width_active(swa));
	cesc_smbus_host cesc_smbus_host_i (.mclk(mclk), .scl(scl), .sda_h(sda_h), .sda(sda));
	// ----
	// Tasks
	// ----
	task chk(input logic [7:0] g, input logic [7:0] x);
		checks_done++;
		if (g !== x)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cmp_all;
		for (int i = 0; i < 6; i++)
			chk(all_b[i * 8 +: 8], e[i * 8 +: 8]);
		chk({3'h0, smo, vsa, sml, swa}, {3'h0, e[3], e[39] & e[3], e[3] & ~e[47], e[3] ? e[46:45] : 2'h0});
	endtask
	// Preamble bytes are always 1 and 2 whatever the real count, to show they are ignored
	task wr(input int n, input logic [7:0] adr, input logic ok);
		cesc_smbus_host_i.start();
		cesc_smbus_host_i.xfer(adr, 1'b1, q, a);
		chk({7'h0, a}, {7'h0, ok});
		for (int i = -2; i < n; i++)
		begin
			if (i >= 0 && i < 6)
				v[i] = v[i] & MSK[i * 8 +: 8];
			cesc_smbus_host_i.xfer(i < 0 ? 8'(i + 3) : v[i], 1'b1, q, a);
			chk({7'h0, a}, {7'h0, ok && i < 6});
			if (ok && i >= 0 && i < 6)
				e[i * 8 +: 8] = v[i] & MSK[i * 8 +: 8];
		end
		cesc_smbus_host_i.stop();
		cmp_all();
	endtask
	task rd;
		cesc_smbus_host_i.start();
		cesc_smbus_host_i.xfer(`CESC_ADDR_READ, 1'b1, q, a);
		chk({7'h0, a}, 8'h01);
		for (int i = 0; i < 7; i++)
		begin
			cesc_smbus_host_i.xfer(8'hFF, i == 6, q, a);
			chk(q, e[(i % 6) * 8 +: 8]);
		end
		cesc_smbus_host_i.stop();
	endtask
	// ----
	// Sequence
	// ----
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		#500000;
		err_total++;
		conclude();
	end
	initial
	begin
		rst = 1'b1;
		pd_n = 1'b1;
		err_total = 0;
		checks_done = 0;
		e = RSTV;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		cmp_all();
		v = '{default: 8'hFF};
		wr(7, `CESC_ADDR_WRITE, 1'b1);
		rd();
		v[0] = 8'h00;
		wr(1, `CESC_ADDR_WRITE, 1'b1);
		v = '{8'h08, 8'h15, 8'hA0, 8'h43, 8'h80, 8'h61, 8'h00};
		wr(6, `CESC_ADDR_WRITE, 1'b1);
		v[0] = 8'hF0;
		wr(2, 8'hA4, 1'b0);
		pd_n = 1'b0;
		repeat (8) @(negedge mclk);
		wr(6, `CESC_ADDR_WRITE, 1'b0);
		pd_n = 1'b1;
		repeat (8) @(negedge mclk);
		rd();
		conclude();
	end
endmodule // tb
bind cesc_bank cesc_bank_properties cesc_bank_properties_i (.mclk(mclk), .rst(rst), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pd_n(pd_n),
	.host_clock_enable_byte(host_clock_enable_byte), .memory_clock_enable_byte(memory_clock_enable_byte),
	.mid_clock_enable_byte(mid_clock_enable_byte), .pci_clock_enable_byte(pci_clock_enable_byte),
	.video_clock_select_byte(video_clock_select_byte), .spread_control_byte(spread_control_byte),
	.spread_modulation_on(spread_modulation_on), .video_spread_active(video_spread_active),
	.spread_mean_lowered(spread_mean_lowered), .spread_width_active(spread_width_active));
